// File: pkg/bbx_pkg.sv
package bbx_pkg;
	localparam int BBX_PC_W     = 15;
	localparam int BBX_LOW_W    = 11;
	localparam int BBX_FADDR_W  = 7;
	localparam int BBX_BIDX_W   = 3;
	localparam int BBX_DATA_W   = 8;
	localparam int BBX_OFS_W    = 9;
	localparam int BBX_LATCH_HI = 6;
	localparam int BBX_LATCH_LO = 3;
	localparam logic [BBX_PC_W-1:0] BBX_PC_ONE   = 15'h0001;
	localparam logic [BBX_PC_W-1:0] BBX_PC_RESET = 15'h0000;

	typedef enum logic [2:0] {
		BBX_OP_NONE  = 3'h0,
		BBX_OP_CLR   = 3'h1,
		BBX_OP_SET   = 3'h2,
		BBX_OP_TSTZ  = 3'h3,
		BBX_OP_TSTO  = 3'h4,
		BBX_OP_OFSJ  = 3'h5,
		BBX_OP_ACCJ  = 3'h6,
		BBX_OP_CALL  = 3'h7
	} bbx_op_type;

	typedef struct packed {
		bbx_op_type             op;
		logic [BBX_FADDR_W-1:0] faddr;
		logic [BBX_BIDX_W-1:0]  bidx;
		logic [BBX_LOW_W-1:0]   lit;
	} bbx_instr_type;

	typedef struct packed {
		logic                   we;
		logic [BBX_FADDR_W-1:0] addr;
		logic [BBX_DATA_W-1:0]  data;
	} bbx_fwrite_type;
endpackage : bbx_pkg

// File: design/bbx_bitop.sv
`timescale 1ns/1ps
module bbx_bitop
	import bbx_pkg::*;
#(
	parameter int DATA_W = BBX_DATA_W
) (
	input  wire logic [DATA_W-1:0]     i_byte,
	input  wire logic [BBX_BIDX_W-1:0] i_bidx,
	input  wire logic                  i_value,
	output logic      [DATA_W-1:0]     o_byte,
	output logic                       o_bit
);
	genvar g;
	// per-bit merge keeps the untouched bits
	generate
		for (g = 0; g < DATA_W; g++) begin : g_bit
			assign o_byte[g] = (i_bidx == BBX_BIDX_W'(g)) ? i_value : i_byte[g];
		end
	endgenerate
	assign o_bit = i_byte[i_bidx];
endmodule : bbx_bitop

// File: design/bbx_exec.sv
`timescale 1ns/1ps
// Functional notes
// - bit clear forces selected bit of addressed byte to zero, others kept
// - bit set forces selected bit of addressed byte to one, others kept
// - zero-skip test: bit zero turns the next instruction into a no-op
// - one-skip test: bit one turns the next instruction into a no-op
// - offset jump: target is incremented pc plus sign-extended 9-bit literal
// - offset jump discards the prefetched instruction, two cycles
// - accumulator jump: target is incremented pc plus unsigned accumulator, two cycles
// - call pushes incremented pc onto the stack head
// - call loads 11-bit literal into pc low bits
// - call takes pc upper bits from latch bits 6:3, two cycles
module bbx_exec
	import bbx_pkg::*;
#(
	parameter int PC_W = BBX_PC_W
) (
	input  wire logic                  i_clock,
	input  wire logic                  i_resetn,
	input  wire logic                  i_valid,
	input  wire bbx_instr_type         i_instr,
	input  wire logic [PC_W-1:0]       i_pc,
	input  wire logic [BBX_DATA_W-1:0] i_file_rdata,
	input  wire logic [BBX_DATA_W-1:0] i_accum,
	input  wire logic [BBX_DATA_W-1:0] i_upper_latch,
	output logic      [BBX_FADDR_W-1:0] o_file_raddr,
	output bbx_fwrite_type             o_file_wr,
	output logic                       o_pc_load,
	output logic      [PC_W-1:0]       o_pc_target,
	output logic                       o_push,
	output logic      [PC_W-1:0]       o_push_addr,
	output logic                       o_discard,
	output logic                       o_status_we
);
	typedef enum logic [1:0] {
		BBX_ST_RUN  = 2'b01,
		BBX_ST_KILL = 2'b10
	} bbx_state_type;

	bbx_state_type            state_r;
	bbx_state_type            state_nxt;
	logic [BBX_DATA_W-1:0]    merged;
	logic                     tbit;
	logic                     op_valid;
	logic                     skip;
	logic                     jump;
	logic [PC_W-1:0]          pc_inc;
	logic [PC_W-1:0]          target;
	logic [BBX_OFS_W-1:0]     ofs;
	logic [BBX_DATA_W-1:0]    file_byte;
	logic                     fwd_hit;

	// instruction in the kill slot is swallowed whatever it is
	assign op_valid = i_valid && (state_r == BBX_ST_RUN);
	assign o_file_raddr = i_instr.faddr;
	assign pc_inc = i_pc + PC_W'(BBX_PC_ONE);
	assign ofs = i_instr.lit[BBX_OFS_W-1:0];

	// forward pending write
	// file array takes our write one edge late; back-to-back rmw would lose it
	assign fwd_hit = o_file_wr.we && (o_file_wr.addr == i_instr.faddr);
	assign file_byte = fwd_hit ? o_file_wr.data : i_file_rdata;

	bbx_bitop u_bitop (
		.i_byte  (file_byte),
		.i_bidx  (i_instr.bidx),
		.i_value (i_instr.op == BBX_OP_SET),
		.o_byte  (merged),
		.o_bit   (tbit)
	);

	assign skip = op_valid && (((i_instr.op == BBX_OP_TSTZ) && !tbit) ||
		((i_instr.op == BBX_OP_TSTO) && tbit));
	assign jump = op_valid && ((i_instr.op == BBX_OP_OFSJ) ||
		(i_instr.op == BBX_OP_ACCJ) || (i_instr.op == BBX_OP_CALL));

	always_comb begin
		target = pc_inc;
		case (i_instr.op)
			BBX_OP_OFSJ: target = pc_inc + PC_W'({{(PC_W-BBX_OFS_W){ofs[BBX_OFS_W-1]}}, ofs});
			BBX_OP_ACCJ: target = pc_inc + PC_W'(i_accum);
			BBX_OP_CALL: target = PC_W'({i_upper_latch[BBX_LATCH_HI:BBX_LATCH_LO],
				i_instr.lit});
			default:     target = pc_inc;
		endcase
	end

	// kill next slot
	// no stall input: the kill slot is always exactly one cycle
	always_comb begin
		state_nxt = BBX_ST_RUN;
		case (state_r)
			BBX_ST_RUN:  state_nxt = (skip || jump) ? BBX_ST_KILL : BBX_ST_RUN;
			BBX_ST_KILL: state_nxt = BBX_ST_RUN;
			default:     state_nxt = BBX_ST_RUN;
		endcase
	end

	always_ff @(posedge i_clock) begin
		if (!i_resetn) begin
			state_r <= BBX_ST_RUN;
		end else begin
			state_r <= state_nxt;
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_resetn) begin
			o_file_wr <= '0;
		end else begin
			o_file_wr.we   <= op_valid &&
				((i_instr.op == BBX_OP_CLR) || (i_instr.op == BBX_OP_SET));
			o_file_wr.addr <= i_instr.faddr;
			o_file_wr.data <= merged;
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_resetn) begin
			o_push      <= 1'b0;
			o_push_addr <= PC_W'(BBX_PC_RESET);
			o_pc_load   <= 1'b0;
			o_pc_target <= PC_W'(BBX_PC_RESET);
		end else begin
			o_push      <= op_valid && (i_instr.op == BBX_OP_CALL);
			o_push_addr <= pc_inc;
			o_pc_load   <= jump;
			o_pc_target <= target;
		end
	end

	// discard is combinational so the fetch stage can squash in the same slot
	assign o_discard = (state_r == BBX_ST_KILL);
	assign o_status_we = 1'b0;

	clr_byte_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
		(op_valid && i_instr.op == BBX_OP_CLR) |=> (o_file_wr.we &&
		!o_file_wr.data[$past(i_instr.bidx)]))
		else $error("bit clear left bit set");
	set_byte_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
		(op_valid && i_instr.op == BBX_OP_SET) |=> (o_file_wr.we &&
		o_file_wr.data[$past(i_instr.bidx)]))
		else $error("bit set left bit clear");
	rmw_keep_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
		(op_valid && (i_instr.op == BBX_OP_SET || i_instr.op == BBX_OP_CLR)) |=>
		((o_file_wr.data ^ $past(file_byte)) & ~(8'h01 << $past(i_instr.bidx))) == 8'h00)
		else $error("other bits changed");
	skip_zero_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
		(op_valid && i_instr.op == BBX_OP_TSTZ) |=> (o_discard == !$past(tbit)))
		else $error("zero-skip wrong");
	skip_one_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
		(op_valid && i_instr.op == BBX_OP_TSTO) |=> (o_discard == $past(tbit)))
		else $error("one-skip wrong");
	ofs_tgt_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
		(op_valid && i_instr.op == BBX_OP_OFSJ) |=> (o_pc_target ==
		PC_W'($past(i_pc) + 15'h0001 + {{6{$past(ofs[8])}}, $past(ofs)})))
		else $error("offset target wrong");
	jump_two_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
		jump |=> (o_pc_load && o_discard) ##1 !o_discard)
		else $error("jump not two cycles");
	acc_tgt_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
		(op_valid && i_instr.op == BBX_OP_ACCJ) |=> (o_pc_target ==
		PC_W'($past(i_pc) + 15'h0001 + {7'h00, $past(i_accum)})))
		else $error("accumulator target wrong");
	call_push_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
		(op_valid && i_instr.op == BBX_OP_CALL) |=> (o_push &&
		o_push_addr == PC_W'($past(i_pc) + 15'h0001)))
		else $error("call push wrong");
	call_tgt_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
		(op_valid && i_instr.op == BBX_OP_CALL) |=> (o_pc_target[BBX_LOW_W-1:0] ==
		$past(i_instr.lit)))
		else $error("call low bits wrong");
	call_hi_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
		(op_valid && i_instr.op == BBX_OP_CALL) |=> (o_pc_target[PC_W-1:BBX_LOW_W] ==
		$past(i_upper_latch[BBX_LATCH_HI:BBX_LATCH_LO])))
		else $error("call upper bits wrong");
	one_cyc_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
		(op_valid && (i_instr.op == BBX_OP_CLR || i_instr.op == BBX_OP_SET)) |=>
		(!o_discard && !o_pc_load && !o_status_we))
		else $error("bit op not single cycle");

	// results stand one edge after the taking edge
	kill_slot_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
		o_discard |=> (!o_file_wr.we && !o_push && !o_pc_load))
		else $error("discarded slot produced a result");
	discard_one_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
		o_discard |=> !o_discard)
		else $error("discard held too long");
	test_quiet_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
		(op_valid && (i_instr.op == BBX_OP_TSTZ || i_instr.op == BBX_OP_TSTO)) |=>
		(!o_file_wr.we && !o_push && !o_pc_load && !o_status_we))
		else $error("bit test changed state");
	jmp_quiet_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
		(op_valid && (i_instr.op == BBX_OP_OFSJ || i_instr.op == BBX_OP_ACCJ)) |=>
		(o_pc_load && !o_push && !o_file_wr.we))
		else $error("jump pushed or wrote");
	call_two_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
		(op_valid && i_instr.op == BBX_OP_CALL) |=> o_discard ##1 !o_discard)
		else $error("call not two cycles");
	push_pair_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
		o_push |-> (o_pc_load && o_discard))
		else $error("push without pc load");
	reset_quiet_a: assert property (@(posedge i_clock)
		!i_resetn |=> (!o_file_wr.we && !o_push && !o_pc_load && !o_discard))
		else $error("outputs not quiet after reset");

	fwd_keep_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
		(op_valid && fwd_hit && (i_instr.op == BBX_OP_SET || i_instr.op == BBX_OP_CLR)) |=>
		(((o_file_wr.data ^ $past(o_file_wr.data)) & ~(8'h01 << $past(i_instr.bidx))) == 8'h00))
		else $error("back-to-back write lost a bit");

	skip_c: cover property (@(posedge i_clock) disable iff (!i_resetn) skip ##1 o_discard);
	call_c: cover property (@(posedge i_clock) disable iff (!i_resetn) o_push);
	wr_c:   cover property (@(posedge i_clock) disable iff (!i_resetn) o_file_wr.we);
	kill_c: cover property (@(posedge i_clock) disable iff (!i_resetn) o_discard && i_valid);
	fwd_c:  cover property (@(posedge i_clock) disable iff (!i_resetn) op_valid && fwd_hit);
endmodule : bbx_exec

// File: tb/bbx_file_model.sv
`timescale 1ns/1ps
module bbx_file_model
	import bbx_pkg::*;
(
	input  wire logic                   i_clock,
	input  wire bbx_fwrite_type         i_wr,
	input  wire logic [BBX_FADDR_W-1:0] i_raddr,
	output logic      [BBX_DATA_W-1:0]  o_rdata
);
	// plain always so the bench may preload the array
	logic [BBX_DATA_W-1:0] mem [128];
	assign o_rdata = mem[i_raddr];
	always @(posedge i_clock) begin
		if (i_wr.we === 1'b1) begin
			mem[i_wr.addr] <= i_wr.data;
		end
	end
endmodule : bbx_file_model

// File: tb/test_bit_and_branch_execute.sv
`timescale 1ns/1ps
module test_bit_and_branch_execute
	import bbx_pkg::*;
;
	logic i_clock, i_resetn, i_valid, o_pc_load, o_push, o_discard, o_status_we;
	bbx_instr_type  i_instr, ins;
	bbx_fwrite_type o_file_wr;
	logic [BBX_PC_W-1:0]    i_pc, o_pc_target, o_push_addr;
	logic [BBX_DATA_W-1:0]  i_file_rdata, i_accum, i_upper_latch, rd;
	logic [BBX_FADDR_W-1:0] o_file_raddr;
	logic [BBX_DATA_W-1:0]  shadow [128];
	logic [BBX_PC_W-1:0]    tgt;
	logic [16:0] q[$];
	logic dead_r, nskip;
	int failures, cmp_count;

	bbx_exec DUT (.i_clock(i_clock), .i_resetn(i_resetn), .i_valid(i_valid),
		.i_instr(i_instr), .i_pc(i_pc), .i_file_rdata(i_file_rdata), .i_accum(i_accum),
		.i_upper_latch(i_upper_latch), .o_file_raddr(o_file_raddr), .o_file_wr(o_file_wr),
		.o_pc_load(o_pc_load), .o_pc_target(o_pc_target), .o_push(o_push),
		.o_push_addr(o_push_addr), .o_discard(o_discard), .o_status_we(o_status_we));
	bbx_file_model fm (.i_clock(i_clock), .i_wr(o_file_wr), .i_raddr(o_file_raddr),
		.o_rdata(i_file_rdata));

	always #2 i_clock = ~i_clock;

	task results;
		if (failures == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : results

	task chk(input logic [16:0] got, input logic [16:0] exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task chk_q(input logic [16:0] got);
		chk(got, (q.size() > 0) ? q.pop_front() : 17'h1ffff);
	endtask : chk_q

	initial begin
		{i_clock, i_resetn, i_valid, dead_r, nskip} = '0;
		{i_instr, i_pc, i_accum, i_upper_latch} = '0;
		void'($urandom(51429));
		for (int k = 0; k < 128; k++) begin
			shadow[k] = 8'($urandom);
			fm.mem[k] = shadow[k];
		end
		repeat (3) @(posedge i_clock);
		i_resetn <= 1'b1;
		for (int n = 0; n < 3000; n++) begin
			@(posedge i_clock);
			ins.op = bbx_op_type'($urandom_range(7, 0));
			ins.faddr = 7'($urandom);
			ins.bidx = 3'($urandom);
			ins.lit = 11'($urandom);
			i_instr <= ins;
			i_valid <= ($urandom_range(7, 0) != 0);
			i_pc <= 15'($urandom);
			i_accum <= 8'($urandom);
			i_upper_latch <= 8'($urandom);
			// slot after a skip or jump is refused
			dead_r <= nskip;
			#1;
			rd = shadow[i_instr.faddr];
			nskip = 1'b0;
			if (i_valid && !dead_r) begin
				case (i_instr.op)
					BBX_OP_CLR: begin
						shadow[i_instr.faddr] = rd & ~(8'h01 << i_instr.bidx);
						q.push_back({2'h1, i_instr.faddr, shadow[i_instr.faddr]});
					end
					BBX_OP_SET: begin
						shadow[i_instr.faddr] = rd | (8'h01 << i_instr.bidx);
						q.push_back({2'h1, i_instr.faddr, shadow[i_instr.faddr]});
					end
					BBX_OP_TSTZ: nskip = ~rd[i_instr.bidx];
					BBX_OP_TSTO: nskip = rd[i_instr.bidx];
					BBX_OP_OFSJ: begin
						nskip = 1'b1;
						tgt = i_pc + BBX_PC_ONE + {{6{i_instr.lit[8]}}, i_instr.lit[8:0]};
						q.push_back({2'h2, tgt});
					end
					BBX_OP_ACCJ: begin
						nskip = 1'b1;
						q.push_back({2'h2, i_pc + BBX_PC_ONE + {7'h00, i_accum}});
					end
					BBX_OP_CALL: begin
						nskip = 1'b1;
						q.push_back({2'h3, i_pc + BBX_PC_ONE});
						q.push_back({2'h2, i_upper_latch[6:3], i_instr.lit});
					end
					default: nskip = 1'b0;
				endcase
			end
		end
		repeat (3) @(posedge i_clock);
		chk(17'(q.size()), 17'h0);
		results();
	end

	// results land one cycle after the taking edge; look mid-cycle
	always @(negedge i_clock) begin
		if (i_resetn === 1'b1) begin
			chk({16'h0, o_status_we}, 17'h0);
			chk({16'h0, o_discard}, {16'h0, dead_r});
			if (o_file_wr.we === 1'b1) chk_q({2'h1, o_file_wr.addr, o_file_wr.data});
			if (o_push === 1'b1) chk_q({2'h3, o_push_addr});
			if (o_pc_load === 1'b1) chk_q({2'h2, o_pc_target});
		end
	end

	initial begin
		#(3100 * 4 + 400);
		failures++;
		results();
	end
endmodule : test_bit_and_branch_execute
